// ### logic/t8wm_pkg.sv
// Purpose: shared constants and carrier types of the 8-bit waveform timer
// Assumes: one 100 MHz clock, registers reached over AHB-Lite, word access only
// Notes: every offset, field position, count and compare reset value and divider count lives here
package t8wm_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLOCK_HZ = 100_000_000; // system clock rate
	localparam int unsigned CLOCK_NS = 10; // system clock period

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL = 4'h0; // mode, action, clock select, pin control
	localparam logic [3:0] OFS_COUNT = 4'h4; // count value
	localparam logic [3:0] OFS_COMPARE = 4'h8; // compare value (buffer in pwm modes)
	localparam logic [3:0] OFS_STATUS = 4'hc; // sticky flags, write one to clear

	// ----------------------------------------------------------------
	// control register field positions
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_MODE_LSB = 0; // waveform_mode_sel [1:0]
	localparam int unsigned CTRL_ACT_LSB = 6; // output_action_sel [7:6]
	localparam int unsigned CTRL_CSEL_LSB = 8; // clock select [10:8]
	localparam int unsigned CTRL_DIR_BIT = 16; // pin direction, 1 = output
	localparam int unsigned CTRL_PORT_BIT = 17; // general port output value
	localparam int unsigned CTRL_FORCE_BIT = 24; // force compare strobe, reads zero
	localparam int unsigned STAT_OVF_BIT = 0; // overflow_flag
	localparam int unsigned STAT_CMP_BIT = 1; // compare_flag

	// ----------------------------------------------------------------
	// counter limits and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [7:0] CNT_ONE = 8'h01;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_COMPARE = 8'h00;

	// ----------------------------------------------------------------
	// prescale limits: divide factor minus one, per clock select code
	// ----------------------------------------------------------------
	localparam logic [9:0] DIV_1_LIM = 10'h000; // n = 1
	localparam logic [9:0] DIV_8_LIM = 10'h007; // n = 8
	localparam logic [9:0] DIV_32_LIM = 10'h01f; // n = 32
	localparam logic [9:0] DIV_64_LIM = 10'h03f; // n = 64
	localparam logic [9:0] DIV_128_LIM = 10'h07f; // n = 128
	localparam logic [9:0] DIV_256_LIM = 10'h0ff; // n = 256
	localparam logic [9:0] DIV_1024_LIM = 10'h3ff; // n = 1024

	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_PHASE = 2'b01,
		MODE_CLEAR_ON_MATCH = 2'b10,
		MODE_FAST = 2'b11
	} t8wm_mode_type;

	typedef enum logic [1:0] {
		ACT_NONE = 2'b00,
		ACT_TOGGLE = 2'b01,
		ACT_LOW_ON_MATCH = 2'b10,
		ACT_HIGH_ON_MATCH = 2'b11
	} t8wm_act_type;

	typedef enum logic [2:0] {
		CSEL_STOP = 3'b000,
		CSEL_DIV1 = 3'b001,
		CSEL_DIV8 = 3'b010,
		CSEL_DIV32 = 3'b011,
		CSEL_DIV64 = 3'b100,
		CSEL_DIV128 = 3'b101,
		CSEL_DIV256 = 3'b110,
		CSEL_DIV1024 = 3'b111
	} t8wm_csel_type;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} t8wm_ahb_req_type;

	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
	} t8wm_ahb_rsp_type;

	typedef struct packed {
		logic pin_out; // level driven toward the pin
		logic pin_oe; // high while the pin is driven
	} t8wm_pin_type;

endpackage

// ### logic/t8wm_prescale.sv
// Purpose: timer tick divider, one-cycle enable pulse every n system clocks
// Assumes: clock select code from t8wm_csel_type, zero stops the tick
// Notes: the tick is registered, so it rises on the same edge as the divider wraps to zero
`timescale 1ns/100ps
`default_nettype none
module t8wm_prescale (
	input wire logic clock,
	input wire logic resetn,
	input wire t8wm_pkg::t8wm_csel_type clk_sel,
	output logic timer_tick
);
	import t8wm_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [9:0] cnt; // cycles since the last tick
		logic tick; // registered enable pulse
	} t8wm_div_state_type;

	t8wm_div_state_type s_r; // current state
	t8wm_div_state_type s_nxt; // next state
	logic [9:0] lim; // divide factor minus one

	// limit lookup per select code
	always_comb begin
		case (clk_sel)
			CSEL_DIV1: lim = DIV_1_LIM;
			CSEL_DIV8: lim = DIV_8_LIM;
			CSEL_DIV32: lim = DIV_32_LIM;
			CSEL_DIV64: lim = DIV_64_LIM;
			CSEL_DIV128: lim = DIV_128_LIM;
			CSEL_DIV256: lim = DIV_256_LIM;
			CSEL_DIV1024: lim = DIV_1024_LIM;
			default: lim = DIV_1_LIM;
		endcase
	end

	// count enable, never a clock of its own
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (clk_sel == CSEL_STOP) begin
			s_nxt.cnt = 10'h000; // stopped: hold the divider at zero
		end else if (s_r.cnt >= lim) begin
			s_nxt.cnt = 10'h000; // a shrinking limit also wraps here
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 10'h001;
		end
	end

	// state register
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign timer_tick = s_r.tick;

endmodule
`default_nettype wire

// ### logic/t8wm_timer.sv
// Purpose: 8-bit timer with one compare channel: normal, clear-on-match,
//          fast pwm and phase-correct pwm waveforms, behind an AHB-Lite slave
// Assumes: single word transfers, zero wait states, response always okay
// Notes: the pin is modelled as level plus output enable only
`timescale 1ns/100ps
`default_nettype none
module t8wm_timer (
	input wire logic clock,
	input wire logic resetn,
	input wire t8wm_pkg::t8wm_ahb_req_type ahb_req,
	output t8wm_pkg::t8wm_ahb_rsp_type ahb_rsp,
	output t8wm_pkg::t8wm_pin_type pin,
	output logic overflow_flag,
	output logic compare_flag
);
	import t8wm_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] count_value; // counter
		logic [7:0] compare_active; // value the comparator sees
		logic [7:0] compare_value; // value software wrote
		t8wm_mode_type waveform_mode_sel; // counting sequence
		t8wm_act_type output_action_sel; // compare output action
		t8wm_csel_type clk_sel; // prescale select
		logic pin_dir; // 1 drives the pin
		logic port_val; // general port level when not overridden
		logic compare_output; // internal waveform level
		logic dir_up; // phase-correct slope, 1 = upward
		logic overflow_flag; // sticky overflow
		logic compare_flag; // sticky compare match
		logic block; // swallow a match on the first tick after a count write
		logic wr_pend; // write data phase due
		logic [3:0] wr_ofs; // offset held from the address phase
		logic pin_out; // registered pin level
		logic pin_oe; // registered pin enable
		logic [31:0] hrdata; // registered read data
		logic hreadyout; // always ready: no wait states
	} t8wm_state_type;

	t8wm_state_type s_r; // current state
	t8wm_state_type s_nxt; // next state
	logic timer_tick; // one-cycle count enable

	// ----------------------------------------------------------------
	// prescaler
	// ----------------------------------------------------------------
	t8wm_prescale u_prescale (
		.clock(clock),
		.resetn(resetn),
		.clk_sel(s_r.clk_sel),
		.timer_tick(timer_tick)
	);

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	// timer first, bus write second, so a software write wins over a tick
	// for registers and loses against a flag that hardware sets
	always_comb begin
		logic is_pwm; // either pwm mode
		logic match; // comparator fires this tick
		logic at_max; // count at max this tick
		logic at_bottom_event; // pwm output restart point
		logic match_up; // phase pwm: match treated as upward
		logic set_ovf; // overflow event
		logic set_cmp; // compare event
		logic addr_phase; // address phase taken this edge
		logic [31:0] wd; // write data
		logic [31:0] rd; // read mux
		logic act_force; // force strobe applies
		is_pwm = 1'b0;
		match = 1'b0;
		at_max = 1'b0;
		at_bottom_event = 1'b0;
		match_up = 1'b0;
		set_ovf = 1'b0;
		set_cmp = 1'b0;
		addr_phase = 1'b0;
		wd = ahb_req.hwdata;
		rd = 32'h0000_0000;
		act_force = 1'b0;
		s_nxt = s_r;

		is_pwm = (s_r.waveform_mode_sel == MODE_FAST) || (s_r.waveform_mode_sel == MODE_PHASE);
		at_max = (s_r.count_value == CNT_MAX);
		// one comparator for every mode; a count write blocks one tick
		match = timer_tick && !s_r.block && (s_r.count_value == s_r.compare_active);
		set_cmp = match;
		if (timer_tick) begin
			s_nxt.block = 1'b0; // the blocked tick is spent
		end

		// counting sequence per mode
		if (timer_tick) begin
			case (s_r.waveform_mode_sel)
				MODE_NORMAL: begin
					// plain up count, wraps past max, no clear
					s_nxt.count_value = s_r.count_value + CNT_ONE;
					set_ovf = at_max;
					s_nxt.dir_up = 1'b1;
				end
				MODE_CLEAR_ON_MATCH: begin
					if (match) begin
						s_nxt.count_value = CNT_BOTTOM; // compare value is top
					end else begin
						// a top below count is missed until wrap
						s_nxt.count_value = s_r.count_value + CNT_ONE;
					end
					set_ovf = at_max && !match; // max to zero
					s_nxt.dir_up = 1'b1;
				end
				MODE_FAST: begin
					// up from bottom to max, then bottom next tick
					if (at_max) begin
						s_nxt.count_value = CNT_BOTTOM;
						s_nxt.compare_active = s_r.compare_value;
						at_bottom_event = 1'b1;
					end else begin
						s_nxt.count_value = s_r.count_value + CNT_ONE;
					end
					set_ovf = at_max; // 256 ticks per period
					s_nxt.dir_up = 1'b1;
				end
				MODE_PHASE: begin
					// up to max, one tick there, down to bottom
					if (s_r.dir_up || s_r.count_value == CNT_BOTTOM) begin
						if (at_max) begin
							s_nxt.count_value = CNT_MAX - CNT_ONE;
							s_nxt.dir_up = 1'b0;
							s_nxt.compare_active = s_r.compare_value;
						end else begin
							s_nxt.count_value = s_r.count_value + CNT_ONE;
							s_nxt.dir_up = 1'b1;
						end
					end else begin
						// 256 up plus 254 down makes 510 ticks
						s_nxt.count_value = s_r.count_value - CNT_ONE;
						if (s_r.count_value == CNT_ONE) begin
							s_nxt.dir_up = 1'b1;
							set_ovf = 1'b1; // reaches bottom
						end
					end
				end
				default: begin
					s_nxt.count_value = s_r.count_value;
				end
			endcase
		end

		// bottom counts as upward, max as downward, so compare 0 stays low
		// and compare max stays high in non-inverted operation
		match_up = (s_r.count_value == CNT_BOTTOM) || (s_r.dir_up && !at_max);

		// waveform generator
		case (s_r.waveform_mode_sel)
			MODE_NORMAL, MODE_CLEAR_ON_MATCH: begin
				if (match) begin
					case (s_r.output_action_sel)
						ACT_TOGGLE: s_nxt.compare_output = !s_r.compare_output;
						ACT_LOW_ON_MATCH: s_nxt.compare_output = 1'b0;
						ACT_HIGH_ON_MATCH: s_nxt.compare_output = 1'b1;
						default: s_nxt.compare_output = s_r.compare_output;
					endcase
				end
			end
			MODE_FAST: begin
				// bottom restart is applied last, so compare max gives a
				// constant level and compare zero a one-tick spike
				case (s_r.output_action_sel)
					ACT_TOGGLE: begin
						if (match) begin
							s_nxt.compare_output = !s_r.compare_output;
						end
					end
					ACT_LOW_ON_MATCH: begin
						// non-inverted: clear on match, set at bottom
						if (match) begin
							s_nxt.compare_output = 1'b0;
						end
						if (at_bottom_event) begin
							s_nxt.compare_output = 1'b1;
						end
					end
					ACT_HIGH_ON_MATCH: begin
						// inverted: set on match, clear at bottom
						if (match) begin
							s_nxt.compare_output = 1'b1;
						end
						if (at_bottom_event) begin
							s_nxt.compare_output = 1'b0;
						end
					end
					default: s_nxt.compare_output = s_r.compare_output;
				endcase
			end
			MODE_PHASE: begin
				// toggle code is reserved here and leaves the output alone
				if (match) begin
					case (s_r.output_action_sel)
						ACT_LOW_ON_MATCH: s_nxt.compare_output = !match_up;
						ACT_HIGH_ON_MATCH: s_nxt.compare_output = match_up;
						default: s_nxt.compare_output = s_r.compare_output;
					endcase
				end
			end
			default: s_nxt.compare_output = s_r.compare_output;
		endcase

		// ----------------------------------------------------------------
		// bus data phase: register writes
		// ----------------------------------------------------------------
		s_nxt.wr_pend = 1'b0;
		if (s_r.wr_pend) begin
			case (s_r.wr_ofs)
				OFS_CTRL: begin
					// action change takes effect at the next match, unbuffered
					s_nxt.waveform_mode_sel = t8wm_mode_type'(wd[CTRL_MODE_LSB +: 2]);
					s_nxt.output_action_sel = t8wm_act_type'(wd[CTRL_ACT_LSB +: 2]);
					s_nxt.clk_sel = t8wm_csel_type'(wd[CTRL_CSEL_LSB +: 3]);
					s_nxt.pin_dir = wd[CTRL_DIR_BIT];
					s_nxt.port_val = wd[CTRL_PORT_BIT];
					act_force = wd[CTRL_FORCE_BIT] && !is_pwm;
				end
				OFS_COUNT: begin
					// a count write overrides the tick and blocks one match
					s_nxt.count_value = wd[7:0];
					s_nxt.block = 1'b1;
				end
				OFS_COMPARE: begin
					s_nxt.compare_value = wd[7:0];
					if (!is_pwm) begin
						s_nxt.compare_active = wd[7:0]; // direct in non-pwm modes
					end
				end
				OFS_STATUS: begin
					// write one to clear; a same-cycle event set wins below
					if (wd[STAT_OVF_BIT]) begin
						s_nxt.overflow_flag = 1'b0;
					end
					if (wd[STAT_CMP_BIT]) begin
						s_nxt.compare_flag = 1'b0;
					end
				end
				default: begin
					// unmapped: write ignored
				end
			endcase
		end

		// forced match: output action only, no flag and no clear
		if (act_force) begin
			case (s_r.output_action_sel)
				ACT_TOGGLE: s_nxt.compare_output = !s_r.compare_output;
				ACT_LOW_ON_MATCH: s_nxt.compare_output = 1'b0;
				ACT_HIGH_ON_MATCH: s_nxt.compare_output = 1'b1;
				default: s_nxt.compare_output = s_r.compare_output;
			endcase
		end

		// sticky flags: hardware set beats a software clear
		if (set_ovf) begin
			s_nxt.overflow_flag = 1'b1;
		end
		if (set_cmp) begin
			s_nxt.compare_flag = 1'b1;
		end

		// ----------------------------------------------------------------
		// pin mux: override by the waveform, direction from software
		// ----------------------------------------------------------------
		s_nxt.pin_out = (s_nxt.output_action_sel != ACT_NONE) ? s_nxt.compare_output :
			s_nxt.port_val;
		s_nxt.pin_oe = s_nxt.pin_dir;

		// ----------------------------------------------------------------
		// bus address phase: decode and read data
		// ----------------------------------------------------------------
		addr_phase = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
		if (addr_phase && ahb_req.hwrite) begin
			s_nxt.wr_pend = 1'b1;
			s_nxt.wr_ofs = ahb_req.haddr[3:0];
		end
		// read data is taken from the next state, so a read right after a
		// write sees the written value
		case (ahb_req.haddr[3:0])
			OFS_CTRL: begin
				rd[CTRL_MODE_LSB +: 2] = s_nxt.waveform_mode_sel;
				rd[CTRL_ACT_LSB +: 2] = s_nxt.output_action_sel;
				rd[CTRL_CSEL_LSB +: 3] = s_nxt.clk_sel;
				rd[CTRL_DIR_BIT] = s_nxt.pin_dir;
				rd[CTRL_PORT_BIT] = s_nxt.port_val;
			end
			OFS_COUNT: rd[7:0] = s_nxt.count_value;
			OFS_COMPARE: rd[7:0] = s_nxt.compare_value;
			OFS_STATUS: begin
				rd[STAT_OVF_BIT] = s_nxt.overflow_flag;
				rd[STAT_CMP_BIT] = s_nxt.compare_flag;
			end
			default: rd = 32'h0000_0000; // unmapped reads zero
		endcase
		if (addr_phase && !ahb_req.hwrite) begin
			s_nxt.hrdata = rd;
		end else begin
			s_nxt.hrdata = 32'h0000_0000;
		end
		s_nxt.hreadyout = 1'b1;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0; // all zero except dir_up and hreadyout, flags clear
			s_r.count_value <= RST_COUNT;
			s_r.compare_value <= RST_COMPARE;
			s_r.compare_active <= RST_COMPARE;
			s_r.dir_up <= 1'b1;
			s_r.hreadyout <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all from state flip-flops except hresp, tied to okay
	// ----------------------------------------------------------------
	assign ahb_rsp.hreadyout = s_r.hreadyout;
	assign ahb_rsp.hresp = 1'b0;
	assign ahb_rsp.hrdata = s_r.hrdata;
	assign pin.pin_out = s_r.pin_out;
	assign pin.pin_oe = s_r.pin_oe;
	assign overflow_flag = s_r.overflow_flag;
	assign compare_flag = s_r.compare_flag;

endmodule
`default_nettype wire

// ### tb/t8wm_timer_sva.sv
// Purpose: bus, pin and flag checks on the timer ports
// Assumes: ports of t8wm_timer only, one clock domain
// Notes: flags may only fall through a status write
`timescale 1ns/100ps
`default_nettype none
module t8wm_timer_sva (
	input wire logic clock,
	input wire logic resetn,
	input wire t8wm_pkg::t8wm_ahb_req_type ahb_req,
	input wire t8wm_pkg::t8wm_ahb_rsp_type ahb_rsp,
	input wire t8wm_pkg::t8wm_pin_type pin,
	input wire logic overflow_flag,
	input wire logic compare_flag
);
	import t8wm_pkg::*;
	logic wr_r; // write data phase pending
	logic rd_r; // read data phase pending
	logic [3:0] adr_r; // offset of the pending transfer
	wire logic take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
	wire logic dir_w = ahb_req.hwdata[CTRL_DIR_BIT];
	wire logic port_w = ahb_req.hwdata[CTRL_PORT_BIT];
	wire logic [1:0] act_w = ahb_req.hwdata[CTRL_ACT_LSB+:2];
	wire logic [1:0] clr_w = (wr_r && adr_r == OFS_STATUS) ? ahb_req.hwdata[1:0] : 2'h0;
	// track the data phase so that its hwdata can be tied to the effect
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			adr_r <= 4'h0;
		end else begin
			wr_r <= take && ahb_req.hwrite;
			rd_r <= take && !ahb_req.hwrite;
			adr_r <= ahb_req.haddr[3:0];
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// address phase to the control word, then its data phase
	sequence ctrl_wr;
		take && ahb_req.hwrite && ahb_req.haddr[3:0] == OFS_CTRL ##1 1'b1;
	endsequence
	// control write whose data phase leaves the output action at none
	sequence port_wr;
		ctrl_wr ##0 act_w == 2'b00;
	endsequence
	a_ready_always: assert property (ahb_rsp.hreadyout)
		else $error("hreadyout low");
	a_okay_resp: assert property (!ahb_rsp.hresp)
		else $error("hresp not okay");
	a_idle_rdata: assert property (!rd_r |-> ahb_rsp.hrdata == 32'h0)
		else $error("hrdata not zero outside a read");
	a_dir_follows: assert property (ctrl_wr |=> pin.pin_oe == $past(dir_w))
		else $error("pin enable does not follow direction bit");
	a_port_value: assert property (port_wr |=> pin.pin_out == $past(port_w))
		else $error("port value not on pin with action zero");
	a_ovf_sticky: assert property ($fell(overflow_flag) |-> $past(clr_w[0]))
		else $error("overflow flag fell without clear");
	a_cmp_sticky: assert property ($fell(compare_flag) |-> $past(clr_w[1]))
		else $error("compare flag fell without clear");
	a_reset_clean: assert property ($rose(resetn) |->
		!overflow_flag && !compare_flag && !pin.pin_out && !pin.pin_oe)
		else $error("outputs not clear after reset");
endmodule
bind t8wm_timer t8wm_timer_sva i_t8wm_timer_sva (.clock(clock), .resetn(resetn),
	.ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .pin(pin),
	.overflow_flag(overflow_flag), .compare_flag(compare_flag));
`default_nettype wire

// ### tb/t8wm_pin_load.sv
// Purpose: load on the compare pin, measures period and high time
// Assumes: pull-up on the pad while the pin is not driven
// Notes: 16-bit counts, enough for periods below 65536 clocks
`timescale 1ns/100ps
`default_nettype none
module t8wm_pin_load (
	input wire logic clock,
	input wire logic resetn,
	input wire t8wm_pkg::t8wm_pin_type pin,
	output logic pad,
	output logic [15:0] period,
	output logic [15:0] high_time,
	output logic [15:0] n_rise
);
	import t8wm_pkg::*;
	logic [15:0] cnt_r; // free running clock count
	logic [15:0] rise_r; // count at the last rising edge
	logic pad_d; // pad one clock ago
	// undriven pad floats to the pull-up, never to the last driven level
	assign pad = pin.pin_oe ? pin.pin_out : 1'b1;
	// edge timing of the pad
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 16'h0;
			rise_r <= 16'h0;
			pad_d <= 1'b1;
			period <= 16'h0;
			high_time <= 16'h0;
			n_rise <= 16'h0;
		end else begin
			cnt_r <= cnt_r + 16'h1;
			pad_d <= pad;
			if (pad && !pad_d) begin
				period <= cnt_r - rise_r;
				rise_r <= cnt_r;
				n_rise <= n_rise + 16'h1;
			end
			if (!pad && pad_d) begin
				high_time <= cnt_r - rise_r;
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: register driven waveform tests of the timer
// Assumes: zero wait slave, load model measures the pad
// Notes: long prescales are measured over three periods
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import t8wm_pkg::*;
	logic clock, resetn, hsel, hwrite;
	logic [31:0] haddr, hwdata;
	logic [1:0] htrans;
	t8wm_ahb_req_type req;
	t8wm_ahb_rsp_type rsp;
	t8wm_pin_type pin;
	logic ovf, cmp, pad;
	logic [15:0] period, high_time, n_rise;
	int miscompares, n_checks;
	int nv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024}; // divide factor per select
	assign req = '{hsel:hsel, haddr:haddr, htrans:htrans, hwrite:hwrite,
		hsize:3'b010, hwdata:hwdata, hready:rsp.hreadyout};
	t8wm_timer i_t8wm_timer (.clock(clock), .resetn(resetn), .ahb_req(req),
		.ahb_rsp(rsp), .pin(pin), .overflow_flag(ovf), .compare_flag(cmp));
	t8wm_pin_load i_t8wm_pin_load (.clock(clock), .resetn(resetn), .pin(pin),
		.pad(pad), .period(period), .high_time(high_time), .n_rise(n_rise));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// sample hready and hrdata mid-cycle, step to the edge that takes them
	task automatic wait_rdy(output logic [31:0] d);
		int i;
		logic r;
		i = 0;
		r = 1'b0;
		while (r !== 1'b1) begin
			@(negedge clock);
			r = rsp.hreadyout;
			d = rsp.hrdata;
			@(posedge clock);
			i++;
			if (i > 50) begin
				miscompares++;
				print_verdict;
			end
		end
	endtask
	// one single word transfer, entered just after a rising edge
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		logic [31:0] d;
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		wait_rdy(d);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy(rd);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, 32'(a), d, x);
	endtask
	task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] x;
		xfer(1'b0, a, 32'h0, x);
		check(n, x, exp);
	endtask
	function automatic logic [31:0] cw(input logic [1:0] m, input logic [1:0] a, input int s);
		return (32'h1 << CTRL_DIR_BIT) | (32'(s) << CTRL_CSEL_LSB) | (32'(a) << CTRL_ACT_LSB) | 32'(m);
	endfunction
	// wait for k rising edges of the pad, bounded
	task automatic edges(input int k);
		int i;
		logic [15:0] n0;
		n0 = n_rise;
		i = 0;
		while (int'(n_rise - n0) < k) begin
			@(negedge clock);
			i++;
			if (i > 40000) begin
				miscompares++;
				print_verdict;
			end
		end
		@(posedge clock);
	endtask
	task automatic run(input string n, input logic [31:0] c, input logic [7:0] v,
		input int per, input int hi);
		wr(OFS_COMPARE, 32'(v));
		wr(OFS_CTRL, c);
		edges(3);
		check(n, 32'(period), per);
		check(n, 32'(high_time), hi);
	endtask
	// steady level: no rising edge over a long stretch
	task automatic flat(input string n, input logic lvl);
		logic [15:0] n0;
		// long enough for a buffered compare to load at top and reach bottom
		repeat (1100) @(posedge clock);
		n0 = n_rise;
		repeat (600) @(posedge clock);
		check(n, 32'(n_rise), 32'(n0));
		check(n, 32'(pad), 32'(lvl));
	endtask
	initial begin
		resetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'b00;
		miscompares = 0;
		n_checks = 0;
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		rdc("ctrl", 32'(OFS_CTRL), 32'h0);
		rdc("count", 32'(OFS_COUNT), 32'h0);
		rdc("compare", 32'(OFS_COMPARE), 32'h0);
		rdc("status", 32'(OFS_STATUS), 32'h0);
		check("pad idle", 32'(pad), 32'h1);
		for (int s = 1; s < 8; s++) begin
			run("match toggle", cw(MODE_CLEAR_ON_MATCH, ACT_TOGGLE, s), 8'h03,
				8 * nv[s], 4 * nv[s]);
		end
		wr(OFS_CTRL, cw(MODE_CLEAR_ON_MATCH, ACT_TOGGLE, 0));
		rdc("match flags", 32'(OFS_STATUS), 32'h2);
		wr(OFS_STATUS, 32'h3);
		rdc("flags clear", 32'(OFS_STATUS), 32'h0);
		// top of 3 below the loaded count: missed until the wrap past max
		wr(OFS_COUNT, 32'hf0);
		wr(OFS_CTRL, cw(MODE_CLEAR_ON_MATCH, ACT_TOGGLE, 1));
		repeat (40) @(posedge clock);
		rdc("match wrap", 32'(OFS_STATUS), 32'h3);
		run("fast", cw(MODE_FAST, ACT_LOW_ON_MATCH, 1), 8'h40, 256,
			65);
		run("fast inv", cw(MODE_FAST, ACT_HIGH_ON_MATCH, 1), 8'h40, 256, 191);
		run("fast spike", cw(MODE_FAST, ACT_LOW_ON_MATCH, 1), 8'h00, 256, 1);
		run("fast toggle", cw(MODE_FAST, ACT_TOGGLE, 1), 8'h40, 512, 256);
		rdc("fast flags", 32'(OFS_STATUS), 32'h3);
		check("flag pins", 32'({cmp, ovf}), 32'h3);
		run("phase", cw(MODE_PHASE, ACT_LOW_ON_MATCH, 1), 8'h40, 510,
			128);
		run("phase inv", cw(MODE_PHASE, ACT_HIGH_ON_MATCH, 1), 8'h40, 510, 382);
		// two rises span a whole slope pair, so bottom is passed after the clear
		wr(OFS_STATUS, 32'h3);
		edges(2);
		rdc("phase flags", 32'(OFS_STATUS), 32'h3);
		// inverted operation: max gives constant low, bottom constant high
		wr(OFS_COMPARE, 32'hff);
		flat("phase max", 1'b0);
		wr(OFS_COMPARE, 32'h00);
		flat("phase zero", 1'b1);
		wr(OFS_CTRL, cw(MODE_PHASE, ACT_HIGH_ON_MATCH, 1) & ~(32'h1 << CTRL_DIR_BIT));
		flat("dir off", 1'b1);
		check("oe off", 32'(pin.pin_oe), 32'h0);
		wr(OFS_COMPARE, 32'hff);
		wr(OFS_CTRL, cw(MODE_FAST, ACT_LOW_ON_MATCH, 1));
		flat("fast max", 1'b1);
		// waveform level is high here, so a low pad shows the port value again
		wr(OFS_CTRL, cw(MODE_NORMAL, ACT_NONE, 0));
		wr(OFS_COUNT, 32'h10);
		rdc("count load", 32'(OFS_COUNT), 32'h10);
		check("port value", 32'(pad), 32'h0);
		print_verdict;
	end
endmodule
`default_nettype wire
